//--- hdl/ppm_defs.svh
// Constants for the peripheral port pin multiplexer
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
// Function-select bit positions
`define PPM_FS_PAD8 0
`define PPM_FS_PAD9 1
`define PPM_FS_PAD56 2
`define PPM_FS_PAD23 3
`define PPM_FS_PAD7 4
`define PPM_FS_MDM_LO 5
`define PPM_FS_MDM_HI 6
`define PPM_FS_PAD01 8
`define PPM_FS_PAD4 13
// Two-bit select field low positions in the output/input select registers
`define PPM_SEL_PAD0 44
`define PPM_SEL_PAD1 8
`define PPM_SEL_PAD4 16
`define PPM_SEL_PAD5 14
`define PPM_SEL_PAD6 12
`define PPM_SEL_PAD7 36
`define PPM_SEL_PAD8 42
`define PPM_SEL_PAD9 10
// Common interface control field low position
`define PPM_CIC_MODE 26
// GPIO bit index for each pad
`define PPM_GPIO_PAD0 22
`define PPM_GPIO_PAD1 4
`define PPM_GPIO_PAD2 24
`define PPM_GPIO_PAD3 25
`define PPM_GPIO_PAD4 8
`define PPM_GPIO_PAD5 7
`define PPM_GPIO_PAD6 6
`define PPM_GPIO_PAD7 18
`define PPM_GPIO_PAD8 21
`define PPM_GPIO_PAD9 5
// Field codes
`define PPM_SEL_GPIO 2'h0
`define PPM_SEL_ALT1 2'h1
`define PPM_SEL_ALT2 2'h2
`define PPM_CIC_DMA 2'h2
`define PPM_CIC_EBM 2'h3
`define PPM_MDM_CTS 2'h2
`define PPM_NPADS 10
`endif

//--- hdl/ppm_pkg.sv
// Types for the peripheral port pin multiplexer
package ppm_pkg;
    typedef logic [1:0] ppm_sel_t;
    typedef enum logic [1:0] {
        PPM_RUN_RESET,
        PPM_RUN_ACTIVE
    } ppm_run_t;
endpackage

//--- hdl/ppm_sync2.sv
// Two-flop synchroniser bank for pad inputs
`timescale 1ns/1ps
module ppm_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;
endmodule // ppm_sync2

//--- hdl/ppm_pin_mux.sv
// Peripheral port pin multiplexer: ten pads routed to GPIO and alternate functions
// Function
// - Pad 0 is GPIO 22 when fsel8=0 and output select 44:45 is 00.
// - Pad 0 feeds external irq 9 when fsel8=0 and input select 3 44:45 is 01.
// - fsel8=1, CI mode 10: pad 0 drives DMA2 ack, pad 1 takes DMA2 request.
// - fsel8=1, CI mode 11: pads 0,1 carry bidirectional hold ack and hold request.
// - Pad 1 is GPIO 4 when fsel8=0 and output select 8:9 is 00.
// - Pad 1 drives SDRAM B chip select 1 when fsel8=0, select 8:9 is 10.
// - fsel3 switches pads 2,3 between GPIO 24/25 and UART B rx/tx.
// - Pad 4 outputs system clock at fsel13=1, else GPIO 8 on select 00.
// - Pad 4 outputs comm baud clock when fsel13=0 and both selects 16:17 are 01.
// - fsel2=0: pad 5 is GPIO 7 on 00, comm receive input on input select 01.
// - fsel2=1: pad 5 is bidirectional DMA2 end-of-transfer or bus-request by CI mode.
// - fsel2=0: pad 6 is GPIO 6 on 00, comm transmit on 01.
// - fsel2=0: pad 6 feeds packet start on input select 2 01; fsel2=1: irq 3.
// - fsel4=0: pad 7 is GPIO 18 on 00, UART B clock on input select 3 01.
// - fsel4=1: pad 7 feeds UART B CTS unless fsel 6:5 is 10, then modem pin 1.
// - Pad 7 carries overlay gate, polarity programmable, when both selects 36:37 are 01.
// - fsel0=0: pad 8 is GPIO 21 on 00, irq 8 on input select 3 01.
// - Pad 8 drives S/PDIF data when fsel0 is 1.
// - fsel1=0: pad 9 is GPIO 5 on 00, SDRAM A chip select 1 on 10.
// - Pad 9 drives the pixel clock when fsel1 is 1.
`timescale 1ns/1ps
`include "ppm_defs.svh"
module ppm_pin_mux
    import ppm_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Configuration
    input wire logic [15:0] i_pin_function_select_reg,
    input wire logic [63:0] i_pin_output_select_reg,
    input wire logic [63:0] i_pin_input_select_reg_1,
    input wire logic [63:0] i_pin_input_select_reg_2,
    input wire logic [63:0] i_pin_input_select_reg_3,
    input wire logic [31:0] i_common_iface_ctrl_reg,
    input wire logic i_overlay_gate_invert,
    // GPIO core side
    input wire logic [31:0] i_gpio_out,
    input wire logic [31:0] i_gpio_oe,
    output logic [31:0] o_gpio_in,
    // Internal function outputs
    input wire logic i_dma2_ack_out,
    input wire logic i_dma2_end_of_xfer_out,
    input wire logic i_dma2_end_of_xfer_oe,
    input wire logic i_ext_master_hold_ack_out,
    input wire logic i_ext_master_hold_ack_oe,
    input wire logic i_ext_master_hold_req_out,
    input wire logic i_ext_master_hold_req_oe,
    input wire logic i_ext_master_bus_req_out,
    input wire logic i_ext_master_bus_req_oe,
    input wire logic i_sdram_b_cs1_n,
    input wire logic i_sdram_a_cs1_n,
    input wire logic i_uart_b_tx,
    input wire logic i_sync_comm_baud_clk,
    input wire logic i_sync_comm_tx,
    input wire logic i_system_clock_out,
    input wire logic i_pixel_overlay_gate,
    input wire logic i_spdif_data_out,
    input wire logic i_pixel_clock_out,
    // Internal function inputs
    output logic o_ext_irq_9,
    output logic o_ext_irq_3,
    output logic o_ext_irq_8,
    output logic o_dma2_req_in_n,
    output logic o_dma2_end_of_xfer_in,
    output logic o_ext_master_hold_ack_in,
    output logic o_ext_master_hold_req_in,
    output logic o_ext_master_bus_req_in,
    output logic o_uart_b_rx,
    output logic o_uart_b_clk_in,
    output logic o_uart_b_cts_n,
    output logic o_sync_comm_rx,
    output logic o_transport_pkt_start_in,
    // Modem port pin 1 as alternate CTS source
    input wire logic i_modem_port_pin_1,
    // Pads
    input wire logic [9:0] i_periph_pad,
    output logic [9:0] o_periph_pad,
    output logic [9:0] o_periph_pad_oe
);
    // Pass through registers on every pad path: outputs come from flops one cycle late; pad inputs take three cycles with the 2-flop sync
    logic [9:0] pad_s;
    logic mdm1_s;
    logic [9:0] pad_o_r, pad_o_nxt, pad_oe_r, pad_oe_nxt;
    logic [31:0] gin_r, gin_nxt;
    logic [12:0] fin_r, fin_nxt;
    ppm_run_t run_r, run_nxt;

    ppm_sync2 #(.WIDTH(11)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({i_modem_port_pin_1, i_periph_pad}),
        .o_sync({mdm1_s, pad_s})
    );

    function automatic ppm_sel_t fld(input logic [63:0] r, input int lo);
        fld = {r[lo], r[lo+1]};
    endfunction

    ppm_sel_t cic;
    logic [1:0] mdm;
    logic [15:0] fs;

    always_comb begin
        fs = i_pin_function_select_reg;
        cic = {i_common_iface_ctrl_reg[`PPM_CIC_MODE], i_common_iface_ctrl_reg[`PPM_CIC_MODE+1]};
        mdm = {fs[`PPM_FS_MDM_HI], fs[`PPM_FS_MDM_LO]};
        pad_o_nxt = '0;
        pad_oe_nxt = '0;
        gin_nxt = '0;
        fin_nxt = 13'h0c08;
        // fin bits: 0 irq9,1 irq3,2 irq8,3 req_n,4 eot,5 hack,6 hreq,7 breq,8 rx,9 clk,10 cts_n,11 scp rx,12 pkt
        // Idle defaults: active-low inputs park high
        // Pad 0
        if (!fs[`PPM_FS_PAD01]) begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD0) == `PPM_SEL_GPIO) begin
                pad_o_nxt[0] = i_gpio_out[`PPM_GPIO_PAD0];
                pad_oe_nxt[0] = i_gpio_oe[`PPM_GPIO_PAD0];
                gin_nxt[`PPM_GPIO_PAD0] = pad_s[0];
            end
            if (fld(i_pin_input_select_reg_3, `PPM_SEL_PAD0) == `PPM_SEL_ALT1)
                fin_nxt[0] = pad_s[0];
        end else if (cic == `PPM_CIC_DMA) begin
            pad_o_nxt[0] = i_dma2_ack_out;
            pad_oe_nxt[0] = 1'b1;
            fin_nxt[3] = pad_s[1];
        end else if (cic == `PPM_CIC_EBM) begin
            pad_o_nxt[0] = i_ext_master_hold_ack_out;
            pad_oe_nxt[0] = i_ext_master_hold_ack_oe;
            fin_nxt[5] = pad_s[0];
            pad_o_nxt[1] = i_ext_master_hold_req_out;
            pad_oe_nxt[1] = i_ext_master_hold_req_oe;
            fin_nxt[6] = pad_s[1];
        end
        // Pad 1
        if (!fs[`PPM_FS_PAD01]) begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD1) == `PPM_SEL_GPIO) begin
                pad_o_nxt[1] = i_gpio_out[`PPM_GPIO_PAD1];
                pad_oe_nxt[1] = i_gpio_oe[`PPM_GPIO_PAD1];
                gin_nxt[`PPM_GPIO_PAD1] = pad_s[1];
            end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD1) == `PPM_SEL_ALT2) begin
                pad_o_nxt[1] = i_sdram_b_cs1_n;
                pad_oe_nxt[1] = 1'b1;
            end
        end
        // Pads 2 and 3
        if (!fs[`PPM_FS_PAD23]) begin
            pad_o_nxt[2] = i_gpio_out[`PPM_GPIO_PAD2];
            pad_oe_nxt[2] = i_gpio_oe[`PPM_GPIO_PAD2];
            gin_nxt[`PPM_GPIO_PAD2] = pad_s[2];
            pad_o_nxt[3] = i_gpio_out[`PPM_GPIO_PAD3];
            pad_oe_nxt[3] = i_gpio_oe[`PPM_GPIO_PAD3];
            gin_nxt[`PPM_GPIO_PAD3] = pad_s[3];
        end else begin
            fin_nxt[8] = pad_s[2];
            pad_o_nxt[3] = i_uart_b_tx;
            pad_oe_nxt[3] = 1'b1;
        end
        // Pad 4
        if (fs[`PPM_FS_PAD4]) begin
            pad_o_nxt[4] = i_system_clock_out;
            pad_oe_nxt[4] = 1'b1;
        end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD4) == `PPM_SEL_GPIO) begin
            pad_o_nxt[4] = i_gpio_out[`PPM_GPIO_PAD4];
            pad_oe_nxt[4] = i_gpio_oe[`PPM_GPIO_PAD4];
            gin_nxt[`PPM_GPIO_PAD4] = pad_s[4];
        end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD4) == `PPM_SEL_ALT1 &&
                     fld(i_pin_input_select_reg_1, `PPM_SEL_PAD4) == `PPM_SEL_ALT1) begin
            pad_o_nxt[4] = i_sync_comm_baud_clk;
            pad_oe_nxt[4] = 1'b1;
        end
        // Pad 5
        if (!fs[`PPM_FS_PAD56]) begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD5) == `PPM_SEL_GPIO) begin
                pad_o_nxt[5] = i_gpio_out[`PPM_GPIO_PAD5];
                pad_oe_nxt[5] = i_gpio_oe[`PPM_GPIO_PAD5];
                gin_nxt[`PPM_GPIO_PAD5] = pad_s[5];
            end
            if (fld(i_pin_input_select_reg_1, `PPM_SEL_PAD5) == `PPM_SEL_ALT1)
                fin_nxt[11] = pad_s[5];
        end else if (cic == `PPM_CIC_DMA) begin
            pad_o_nxt[5] = i_dma2_end_of_xfer_out;
            pad_oe_nxt[5] = i_dma2_end_of_xfer_oe;
            fin_nxt[4] = pad_s[5];
        end else if (cic == `PPM_CIC_EBM) begin
            pad_o_nxt[5] = i_ext_master_bus_req_out;
            pad_oe_nxt[5] = i_ext_master_bus_req_oe;
            fin_nxt[7] = pad_s[5];
        end
        // Pad 6
        if (!fs[`PPM_FS_PAD56]) begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD6) == `PPM_SEL_GPIO) begin
                pad_o_nxt[6] = i_gpio_out[`PPM_GPIO_PAD6];
                pad_oe_nxt[6] = i_gpio_oe[`PPM_GPIO_PAD6];
                gin_nxt[`PPM_GPIO_PAD6] = pad_s[6];
            end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD6) == `PPM_SEL_ALT1) begin
                pad_o_nxt[6] = i_sync_comm_tx;
                pad_oe_nxt[6] = 1'b1;
            end
            if (fld(i_pin_input_select_reg_2, `PPM_SEL_PAD6) == `PPM_SEL_ALT1)
                fin_nxt[12] = pad_s[6];
        end else begin
            fin_nxt[1] = pad_s[6];
        end
        // Pad 7
        if (!fs[`PPM_FS_PAD7]) begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD7) == `PPM_SEL_GPIO) begin
                pad_o_nxt[7] = i_gpio_out[`PPM_GPIO_PAD7];
                pad_oe_nxt[7] = i_gpio_oe[`PPM_GPIO_PAD7];
                gin_nxt[`PPM_GPIO_PAD7] = pad_s[7];
            end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD7) == `PPM_SEL_ALT1 &&
                         fld(i_pin_input_select_reg_1, `PPM_SEL_PAD7) == `PPM_SEL_ALT1) begin
                pad_o_nxt[7] = i_pixel_overlay_gate ^ i_overlay_gate_invert;
                pad_oe_nxt[7] = 1'b1;
            end
            if (fld(i_pin_input_select_reg_3, `PPM_SEL_PAD7) == `PPM_SEL_ALT1)
                fin_nxt[9] = pad_s[7];
        end else if (mdm != `PPM_MDM_CTS) begin
            fin_nxt[10] = pad_s[7];
        end
        if (mdm == `PPM_MDM_CTS)
            fin_nxt[10] = mdm1_s;
        // Pad 8
        if (fs[`PPM_FS_PAD8]) begin
            pad_o_nxt[8] = i_spdif_data_out;
            pad_oe_nxt[8] = 1'b1;
        end else begin
            if (fld(i_pin_output_select_reg, `PPM_SEL_PAD8) == `PPM_SEL_GPIO) begin
                pad_o_nxt[8] = i_gpio_out[`PPM_GPIO_PAD8];
                pad_oe_nxt[8] = i_gpio_oe[`PPM_GPIO_PAD8];
                gin_nxt[`PPM_GPIO_PAD8] = pad_s[8];
            end
            if (fld(i_pin_input_select_reg_3, `PPM_SEL_PAD8) == `PPM_SEL_ALT1)
                fin_nxt[2] = pad_s[8];
        end
        // Pad 9
        if (fs[`PPM_FS_PAD9]) begin
            pad_o_nxt[9] = i_pixel_clock_out;
            pad_oe_nxt[9] = 1'b1;
        end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD9) == `PPM_SEL_GPIO) begin
            pad_o_nxt[9] = i_gpio_out[`PPM_GPIO_PAD9];
            pad_oe_nxt[9] = i_gpio_oe[`PPM_GPIO_PAD9];
            gin_nxt[`PPM_GPIO_PAD9] = pad_s[9];
        end else if (fld(i_pin_output_select_reg, `PPM_SEL_PAD9) == `PPM_SEL_ALT2) begin
            pad_o_nxt[9] = i_sdram_a_cs1_n;
            pad_oe_nxt[9] = 1'b1;
        end
        // Drivers stay released in the first cycle after reset so no pad fights a board strap
        run_nxt = PPM_RUN_ACTIVE;
        case (run_r)
            PPM_RUN_RESET: begin
                pad_oe_nxt = '0;
            end
            PPM_RUN_ACTIVE: begin
                run_nxt = PPM_RUN_ACTIVE;
            end
            default: begin
                run_nxt = PPM_RUN_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pad_o_r <= '0;
            pad_oe_r <= '0;
            gin_r <= '0;
            fin_r <= 13'h0c08;
            run_r <= PPM_RUN_RESET;
        end else begin
            pad_o_r <= pad_o_nxt;
            pad_oe_r <= pad_oe_nxt;
            gin_r <= gin_nxt;
            fin_r <= fin_nxt;
            run_r <= run_nxt;
        end
    end

    assign o_periph_pad = pad_o_r;
    assign o_periph_pad_oe = pad_oe_r;
    assign o_gpio_in = gin_r;
    assign o_ext_irq_9 = fin_r[0];
    assign o_ext_irq_3 = fin_r[1];
    assign o_ext_irq_8 = fin_r[2];
    assign o_dma2_req_in_n = fin_r[3];
    assign o_dma2_end_of_xfer_in = fin_r[4];
    assign o_ext_master_hold_ack_in = fin_r[5];
    assign o_ext_master_hold_req_in = fin_r[6];
    assign o_ext_master_bus_req_in = fin_r[7];
    assign o_uart_b_rx = fin_r[8];
    assign o_uart_b_clk_in = fin_r[9];
    assign o_uart_b_cts_n = fin_r[10];
    assign o_sync_comm_rx = fin_r[11];
    assign o_transport_pkt_start_in = fin_r[12];

    // Assertions
    sdram_b_cs_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (!$past(i_pin_function_select_reg[8]) && $past(i_pin_output_select_reg[8])
         && !$past(i_pin_output_select_reg[9]) && $past(run_r) == PPM_RUN_ACTIVE)
        |-> o_periph_pad_oe[1] && o_periph_pad[1] == $past(i_sdram_b_cs1_n))
        else $error("pad 1 chip select wrong");
    pixel_clock_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(i_pin_function_select_reg[1]) && $past(run_r) == PPM_RUN_ACTIVE)
        |-> o_periph_pad_oe[9] && o_periph_pad[9] == $past(i_pixel_clock_out))
        else $error("pad 9 pixel clock wrong");
    dma_req_release_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(i_pin_function_select_reg[8]) && $past(i_common_iface_ctrl_reg[26])
         && !$past(i_common_iface_ctrl_reg[27]))
        |-> !o_periph_pad_oe[1] && o_periph_pad[0] == $past(i_dma2_ack_out))
        else $error("dma request pad not released");
    startup_release_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(run_r) == PPM_RUN_RESET) |-> o_periph_pad_oe == 10'h000)
        else $error("pad driven during startup");
    spdif_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(i_pin_function_select_reg[0]) && $past(run_r) == PPM_RUN_ACTIVE)
        |-> o_periph_pad_oe[8] && o_periph_pad[8] == $past(i_spdif_data_out))
        else $error("pad 8 spdif wrong");
    cts_modem_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(i_pin_function_select_reg[6:5]) == 2'h2) |-> o_uart_b_cts_n == $past(mdm1_s))
        else $error("cts source wrong");
    system_clock_out_out_a: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(i_pin_function_select_reg[13]) && $past(run_r) == PPM_RUN_ACTIVE)
        |-> o_periph_pad[4] == $past(i_system_clock_out))
        else $error("pad 4 clock wrong");
endmodule // ppm_pin_mux

//--- tb/ppm_pad_model.sv
// Far-side model of the ten peripheral port pads: external devices and an idle toggle pattern
`timescale 1ns/1ps
module ppm_pad_model (
    // Clock
    input wire logic i_clock,
    // Block pad drivers
    input wire logic [9:0] i_pad_out,
    input wire logic [9:0] i_pad_oe,
    // External device drive request
    input wire logic [9:0] i_drive_en,
    input wire logic [9:0] i_drive_val,
    // Resolved pad level
    output logic [9:0] o_pad_level
);
    // --------------------------------------------------------------
    // Idle pattern
    // --------------------------------------------------------------
    // An undriven pad toggles every cycle so a stale value is never mistaken for data
    logic [9:0] idle_r = 10'h155;

    always @(posedge i_clock) begin
        idle_r <= ~idle_r;
    end

    // --------------------------------------------------------------
    // Pad resolution
    // --------------------------------------------------------------
    // The outside party backs off wherever the block drives, so a bidirectional
    // flag never sees two drivers; elsewhere the external drive or the idle pattern sets the level
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (i_pad_oe[i]) begin
                o_pad_level[i] = i_pad_out[i];
            end else if (i_drive_en[i]) begin
                o_pad_level[i] = i_drive_val[i];
            end else begin
                o_pad_level[i] = idle_r[i];
            end
        end
    end
endmodule // ppm_pad_model

//--- tb/tb_top.sv
// Self-checking testbench for the peripheral port pin multiplexer
`timescale 1ns/1ps
module tb_top;
    // --------------------------------------------------------------
    // Stimulus and observation
    // --------------------------------------------------------------
    logic clk;
    logic rst;
    logic [15:0] fsel;
    logic [63:0] pin_output_select_reg, gis1, gis2, gis3;
    logic [31:0] cic, gout, goe;
    logic inv, modem_pin;
    logic [17:0] fn;
    logic [9:0] drv_en, drv_val, e, eo, lvl, d;
    logic [31:0] w;
    logic [12:0] x;
    wire [9:0] pad_lvl, pad_out, pad_oe;
    wire [31:0] gpio_in;
    wire [12:0] fin;
    int n_errors = 0;
    int check_count = 0;
    int gidx[10] = '{22, 4, 24, 25, 8, 7, 6, 18, 21, 5};

    ppm_pin_mux ppm_pin_mux_inst (
        .i_clock(clk), .i_rst(rst),
        .i_pin_function_select_reg(fsel), .i_pin_output_select_reg(pin_output_select_reg),
        .i_pin_input_select_reg_1(gis1), .i_pin_input_select_reg_2(gis2),
        .i_pin_input_select_reg_3(gis3), .i_common_iface_ctrl_reg(cic),
        .i_overlay_gate_invert(inv), .i_gpio_out(gout), .i_gpio_oe(goe), .o_gpio_in(gpio_in),
        .i_dma2_ack_out(fn[0]), .i_dma2_end_of_xfer_out(fn[1]), .i_dma2_end_of_xfer_oe(fn[2]),
        .i_ext_master_hold_ack_out(fn[3]), .i_ext_master_hold_ack_oe(fn[4]),
        .i_ext_master_hold_req_out(fn[5]), .i_ext_master_hold_req_oe(fn[6]),
        .i_ext_master_bus_req_out(fn[7]), .i_ext_master_bus_req_oe(fn[8]),
        .i_sdram_b_cs1_n(fn[9]), .i_sdram_a_cs1_n(fn[10]), .i_uart_b_tx(fn[11]),
        .i_sync_comm_baud_clk(fn[12]), .i_sync_comm_tx(fn[13]), .i_system_clock_out(fn[14]),
        .i_pixel_overlay_gate(fn[15]), .i_spdif_data_out(fn[16]), .i_pixel_clock_out(fn[17]),
        .o_ext_irq_9(fin[0]), .o_ext_irq_3(fin[1]), .o_ext_irq_8(fin[2]), .o_dma2_req_in_n(fin[3]),
        .o_dma2_end_of_xfer_in(fin[4]), .o_ext_master_hold_ack_in(fin[5]),
        .o_ext_master_hold_req_in(fin[6]), .o_ext_master_bus_req_in(fin[7]), .o_uart_b_rx(fin[8]),
        .o_uart_b_clk_in(fin[9]), .o_uart_b_cts_n(fin[10]), .o_sync_comm_rx(fin[11]),
        .o_transport_pkt_start_in(fin[12]), .i_modem_port_pin_1(modem_pin),
        .i_periph_pad(pad_lvl), .o_periph_pad(pad_out), .o_periph_pad_oe(pad_oe)
    );

    ppm_pad_model ppm_pad_model_inst (
        .i_clock(clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
        .i_drive_en(drv_en), .i_drive_val(drv_val), .o_pad_level(pad_lvl)
    );

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Touches only the two bits of one pad's field; everything else stays zero
    function automatic logic [63:0] fld(input int pos, input logic [1:0] code);
        logic [63:0] r;
        r = '0;
        r[pos] = code[1];
        r[pos+1] = code[0];
        return r;
    endfunction

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h got %h", name, exp, got);
        end
    endtask

    // Pad outputs are compared only where the pad should be driven
    task automatic check_all(input logic [9:0] eoe, input logic [9:0] eout, input logic [12:0] efin);
        check_word("pad_oe", {22'h0, eoe}, {22'h0, pad_oe});
        check_word("pad_out", {22'h0, eout & eoe}, {22'h0, pad_out & eoe});
        check_word("func_in", {19'h0, efin}, {19'h0, fin});
    endtask

    // Covers the 2-flop pad sync plus the registered outputs and the round trip
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Clock and watchdog
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test;
    end

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1; fsel = '0; pin_output_select_reg = '0; gis1 = '0; gis2 = '0; gis3 = '0; cic = '0; inv = 1'b0;
        gout = '0; goe = '0; fn = '0; modem_pin = 1'b0; drv_en = '0; drv_val = '0;
        repeat (2) @(posedge clk);
        #1;
        check_all(10'h000, 10'h000, 13'h0c08);
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        settle;
        for (int v = 0; v < 2; v++) begin
            gout = v ? 32'haaaaaaaa : 32'h55555555;
            goe = '1;
            drv_en = '0;
            settle;
            for (int i = 0; i < 10; i++) e[i] = gout[gidx[i]];
            check_all(10'h3ff, e, 13'h0c08);
            goe = '0;
            drv_en = '1;
            drv_val = v ? 10'h2a5 : 10'h15a;
            settle;
            w = '0;
            for (int i = 0; i < 10; i++) w[gidx[i]] = drv_val[i];
            check_word("gpio_in", w, gpio_in);
        end
        for (int v = 0; v < 2; v++) begin
            fn = v ? 18'h2aaaa : 18'h15555;
            d = v ? 10'h2a5 : 10'h15a;
            drv_val = d;
            inv = v[0];
            fsel = 16'h200b;
            pin_output_select_reg = fld(8, 2'h2) | fld(12, 2'h1);
            gis1 = fld(14, 2'h1);
            gis2 = '0;
            gis3 = fld(44, 2'h1) | fld(36, 2'h1);
            cic = '0;
            settle;
            e = '0; e[8] = fn[16]; e[9] = fn[17]; e[3] = fn[11]; e[4] = fn[14]; e[1] = fn[9]; e[6] = fn[13];
            x = 13'h0c08; x[0] = d[0]; x[8] = d[2]; x[11] = d[5]; x[9] = d[7];
            check_all(10'h35a, e, x);
            fsel = '0;
            pin_output_select_reg = fld(10, 2'h2) | fld(16, 2'h1) | fld(36, 2'h1);
            gis1 = fld(16, 2'h1) | fld(36, 2'h1);
            gis2 = fld(12, 2'h1);
            gis3 = fld(42, 2'h1);
            settle;
            e = '0; e[9] = fn[10]; e[4] = fn[12]; e[7] = fn[15] ^ inv;
            x = 13'h0c08; x[2] = d[8]; x[12] = d[6];
            check_all(10'h290, e, x);
            // DMA handshake mode, with the modem pin taking over clear-to-send on the second pass
            fsel = 16'h0114 | (v ? 16'h0040 : 16'h0000);
            pin_output_select_reg = '0; gis1 = '0; gis2 = '0; gis3 = '0;
            cic = 32'h04000000;
            modem_pin = ~d[7];
            settle;
            eo = 10'h001 | (fn[2] ? 10'h020 : 10'h000);
            e = '0; e[0] = fn[0]; e[5] = fn[1];
            lvl = (eo & e) | (~eo & d);
            x = 13'h0c08; x[3] = d[1]; x[4] = lvl[5]; x[1] = d[6]; x[10] = v ? modem_pin : d[7];
            check_all(eo, e, x);
            // External bus master arbitration mode
            fsel = 16'h0104;
            cic = 32'h0c000000;
            settle;
            eo = '0; eo[0] = fn[4]; eo[1] = fn[6]; eo[5] = fn[8];
            e = '0; e[0] = fn[3]; e[1] = fn[5]; e[5] = fn[7];
            lvl = (eo & e) | (~eo & d);
            x = 13'h0c08; x[5] = lvl[0]; x[6] = lvl[1]; x[7] = lvl[5]; x[1] = d[6];
            check_all(eo, e, x);
        end
        end_of_test;
    end
endmodule // tb_top
